// *** core/ccc_crc8.sv ***
module ccc_crc8 (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Byte stream
	input wire logic start_in,
	input wire logic byte_valid_in,
	input wire logic [7:0] byte_in,
	// Running value
	output logic [7:0] crc_out
);
	import ccc_pkg::*;
	logic [7:0] crc_q;
	logic [7:0] crc_d;
	always_comb begin
		crc_d = crc_q;
		if (start_in) begin
			crc_d = CRC_INIT;
		end else if (byte_valid_in) begin
			crc_d = ccc_crc_byte(crc_q, byte_in);
		end
	end
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			crc_q <= CRC_INIT;
		end else begin
			crc_q <= crc_d;
		end
	end
	assign crc_out = crc_q;
endmodule // ccc_crc8

// *** core/ccc_ctrl.sv ***
// Behaviour
// - CRC check only when fuse enable set
// - Compute and compare CRC per transaction
// - Mismatch drops command, flags, masked interrupt
// - CRC-8 J1850, poly 1D, preset FF
// - On-enable bit drives charger in run/standby
// - Undervoltage crossing clears on-enable bit
// - Run 60 uA, standby 10 uA
// - Off-enable bit drives charger in quick-off, 10 uA
// - Undervoltage crossing clears off-enable bit
// - Voltage code maps 1.8, 2.0-3.3, 3.6 V
// - Voltage code default from fuse field
module ccc_ctrl (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Fuses
	input wire logic fuse_crc_enable_in,
	input wire logic [3:0] fuse_backup_charge_voltage_code_in,
	// Received transaction from the I2C slave
	input wire logic txn_start_in,
	input wire logic txn_byte_valid_in,
	input wire logic [7:0] txn_byte_in,
	input wire logic txn_end_in,
	// Power state and supply
	input wire ccc_pkg::ccc_pstate_t power_state_in,
	input wire logic input_undervoltage_threshold_in,
	// Interrupt control
	input wire logic crc_irq_mask_in,
	input wire logic crc_flag_clear_in,
	// Status and interrupt
	output logic crc_flag_out,
	output logic irq_out_n,
	// Configuration readback
	output logic backup_charge_on_enable_out,
	output logic backup_charge_off_enable_out,
	output logic [3:0] backup_charge_voltage_code_out,
	// Charger drive
	output logic backup_cell_pin_charge_out,
	output ccc_pkg::ccc_curr_t backup_cell_pin_current_out,
	output logic [11:0] backup_cell_pin_target_mv_out
);
	import ccc_pkg::*;
	// Transaction capture: last two bytes are data and CRC
	logic [7:0] data_q, data_d, crcb_q, crcb_d;
	logic [1:0] cnt_q, cnt_d;
	logic [7:0] crc_pre_q, crc_pre_d;
	logic [7:0] crc_run;
	logic on_q, on_d, off_q, off_d, flag_q, flag_d;
	logic [3:0] code_q, code_d;
	logic fuse_load_q;
	logic uv_q;
	logic crc_ok, accept;
	ccc_crc8 u_crc (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.start_in(txn_start_in),
		.byte_valid_in(txn_byte_valid_in),
		.byte_in(txn_byte_in),
		.crc_out(crc_run)
	);
	// Capture path keeps the CRC value before the last byte, so the check byte
	// itself is excluded from the computed value.
	always_comb begin
		data_d = data_q;
		crcb_d = crcb_q;
		cnt_d = cnt_q;
		crc_pre_d = crc_pre_q;
		if (txn_start_in) begin
			cnt_d = 2'h0;
		end else if (txn_byte_valid_in) begin
			data_d = crcb_q;
			crcb_d = txn_byte_in;
			crc_pre_d = crc_run;
			if (cnt_q != 2'h3) begin
				cnt_d = cnt_q + 2'h1;
			end
		end else if (txn_end_in) begin
			// Count drops at the end so a stray end strobe cannot replay a command
			cnt_d = 2'h0;
		end
	end
	assign crc_ok = (crc_pre_q == crcb_q);
	always_comb begin
		if (fuse_crc_enable_in) begin
			accept = txn_end_in && (cnt_q >= 2'h2) && crc_ok;
		end else begin
			accept = txn_end_in && (cnt_q >= 2'h1);
		end
	end
	wire [7:0] cmd = fuse_crc_enable_in ? data_q : crcb_q;
	wire crc_fail = fuse_crc_enable_in && txn_end_in && (cnt_q >= 2'h1) && !accept;
	// Undervoltage edge, either direction
	wire uv_cross = input_undervoltage_threshold_in ^ uv_q;
	always_comb begin
		on_d = on_q;
		off_d = off_q;
		code_d = code_q;
		if (fuse_load_q) begin
			code_d = fuse_backup_charge_voltage_code_in;
		end
		if (accept) begin
			on_d = cmd[FLD_ON_EN];
			off_d = cmd[FLD_OFF_EN];
			code_d = cmd[FLD_VCODE_LO +: VCODE_W];
		end
		// Supply event overrides the enables of a same-cycle write; the code is still written
		if (uv_cross) begin
			on_d = 1'b0;
			off_d = 1'b0;
		end
	end
	always_comb begin
		flag_d = flag_q;
		if (crc_flag_clear_in) begin
			flag_d = 1'b0;
		end
		if (crc_fail) begin
			flag_d = 1'b1;
		end
	end
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			data_q <= 8'h00;
			crcb_q <= 8'h00;
			cnt_q <= 2'h0;
			crc_pre_q <= CRC_INIT;
			on_q <= ON_EN_RST;
			off_q <= OFF_EN_RST;
			code_q <= VCODE_RST;
			flag_q <= 1'b0;
			fuse_load_q <= 1'b1;
			uv_q <= 1'b0;
		end else begin
			data_q <= data_d;
			crcb_q <= crcb_d;
			cnt_q <= cnt_d;
			crc_pre_q <= crc_pre_d;
			on_q <= on_d;
			off_q <= off_d;
			code_q <= code_d;
			flag_q <= flag_d;
			fuse_load_q <= 1'b0;
			uv_q <= input_undervoltage_threshold_in;
		end
	end
	// Charger drive from state and enables
	always_comb begin
		backup_cell_pin_charge_out = 1'b0;
		backup_cell_pin_current_out = CCC_I_NONE;
		unique case (power_state_in)
			CCC_PS_RUN: begin
				if (on_q) begin
					backup_cell_pin_charge_out = 1'b1;
					backup_cell_pin_current_out = CCC_I_HIGH;
				end
			end
			CCC_PS_STBY: begin
				if (on_q) begin
					backup_cell_pin_charge_out = 1'b1;
					backup_cell_pin_current_out = CCC_I_LOW;
				end
			end
			CCC_PS_QUICK_POWERUP_OFF_STATE: begin
				if (off_q) begin
					backup_cell_pin_charge_out = 1'b1;
					backup_cell_pin_current_out = CCC_I_LOW;
				end
			end
			CCC_PS_OTHER: begin
			end
		endcase
	end
	always_comb begin
		if (code_q == 4'h0) begin
			backup_cell_pin_target_mv_out = MV_MIN;
		end else if (code_q == 4'hF) begin
			backup_cell_pin_target_mv_out = MV_MAX;
		end else begin
			backup_cell_pin_target_mv_out = 12'(MV_BASE + MV_STEP * 12'(code_q - 4'h1));
		end
	end
	assign crc_flag_out = flag_q;
	assign irq_out_n = !(flag_q && !crc_irq_mask_in);
	assign backup_charge_on_enable_out = on_q;
	assign backup_charge_off_enable_out = off_q;
	assign backup_charge_voltage_code_out = code_q;

	chk_fail_sets_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		crc_fail |=> crc_flag_out) else $error("CRC failure did not set flag");
	chk_irq_masked: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		crc_irq_mask_in |-> irq_out_n) else $error("Masked interrupt asserted");
	chk_irq_unmasked: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(crc_flag_out && !crc_irq_mask_in) |-> !irq_out_n) else $error("Interrupt not asserted");
	chk_fail_drops_cmd: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(crc_fail && !uv_cross && !fuse_load_q) |=> $stable(code_q))
		else $error("Bad command changed code");
	chk_nocheck_accepts: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(!fuse_crc_enable_in && txn_end_in && cnt_q != 2'h0 && !crc_flag_clear_in)
		|=> crc_flag_out == $past(crc_flag_out)) else $error("Check ran while disabled");
	chk_uv_clears_on: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		uv_cross |=> !on_q && !off_q) else $error("Undervoltage did not clear enables");
	chk_on_gates: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(power_state_in == CCC_PS_RUN || power_state_in == CCC_PS_STBY)
		|-> backup_cell_pin_charge_out == on_q) else $error("On-state charge wrong");
	chk_run_current: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(power_state_in == CCC_PS_RUN && on_q) |-> backup_cell_pin_current_out == CCC_I_HIGH)
		else $error("Run current wrong");
	chk_stby_current: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(power_state_in == CCC_PS_STBY && on_q) |-> backup_cell_pin_current_out == CCC_I_LOW)
		else $error("Standby current wrong");
	chk_qpu_charge: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(power_state_in == CCC_PS_QUICK_POWERUP_OFF_STATE) |-> backup_cell_pin_charge_out == off_q)
		else $error("Quick-off charge wrong");
	chk_other_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(power_state_in == CCC_PS_OTHER) |-> !backup_cell_pin_charge_out)
		else $error("Charger on in other state");
	chk_fuse_load: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(fuse_load_q && !accept) |=> code_q == $past(fuse_backup_charge_voltage_code_in))
		else $error("Fuse code not loaded");
	chk_code_max: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		code_q == 4'hF |-> backup_cell_pin_target_mv_out == 12'hE10)
		else $error("Top code wrong");
	// Whole checked transaction: start, command, check byte, end on consecutive edges
	logic [3:0] chk_cmd_code;
	assign chk_cmd_code = txn_byte_in[FLD_VCODE_LO +: VCODE_W];
	sequence s_cmd_then_crc;
		txn_start_in ##1 txn_byte_valid_in ##1 txn_byte_valid_in ##1 txn_end_in;
	endsequence
	sequence s_checked_end;
		fuse_crc_enable_in && !uv_cross && !crc_flag_clear_in;
	endsequence
	chk_crc_result: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(s_cmd_then_crc ##0 s_checked_end) |=> crc_flag_out == ($past(crc_flag_out)
		|| (ccc_crc_byte(CRC_INIT, $past(txn_byte_in, 3)) != $past(txn_byte_in, 2))))
		else $error("Check result wrong");
	chk_good_loads: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(s_cmd_then_crc ##0 s_checked_end) |=> (code_q == $past(chk_cmd_code, 3))
		|| (ccc_crc_byte(CRC_INIT, $past(txn_byte_in, 3)) != $past(txn_byte_in, 2)))
		else $error("Good command not loaded");
endmodule // ccc_ctrl

// *** core/ccc_pkg.sv ***
package ccc_pkg;
	// CRC-8 per SAE J1850
	localparam logic [7:0] CRC_POLY = 8'h1D;
	localparam logic [7:0] CRC_INIT = 8'hFF;
	localparam int CMD_W = 8;
	// Configuration command field positions inside the data byte
	localparam int FLD_ON_EN = 0;
	localparam int FLD_OFF_EN = 1;
	localparam int FLD_VCODE_LO = 4;
	localparam int VCODE_W = 4;
	// Reset values
	localparam logic ON_EN_RST = 1'b0;
	localparam logic OFF_EN_RST = 1'b0;
	localparam logic [3:0] VCODE_RST = 4'h0;
	// Target voltage table, millivolts
	localparam logic [11:0] MV_MIN = 12'h708;
	localparam logic [11:0] MV_BASE = 12'h7D0;
	localparam logic [11:0] MV_STEP = 12'h064;
	localparam logic [11:0] MV_MAX = 12'hE10;
	typedef enum logic [1:0] {
		CCC_PS_OTHER = 2'b00,
		CCC_PS_RUN = 2'b01,
		CCC_PS_STBY = 2'b10,
		CCC_PS_QUICK_POWERUP_OFF_STATE = 2'b11
	} ccc_pstate_t;
	typedef enum logic [1:0] {
		CCC_I_NONE = 2'b00,
		CCC_I_LOW = 2'b01,
		CCC_I_HIGH = 2'b10
	} ccc_curr_t;
	// Next CRC after one byte, MSB first
	function automatic logic [7:0] ccc_crc_byte(input logic [7:0] crc, input logic [7:0] data);
		logic [7:0] c;
		c = crc ^ data;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
		end
		return c;
	endfunction
endpackage

// *** dv/ccc_ctrl_tb.sv ***
module ccc_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ccc_pkg::*;
	typedef struct packed {logic [7:0] cmd; ccc_pstate_t ps; logic chg; ccc_curr_t cur;} ccc_row_t;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic crc_en = 1'b1;
	logic uv = 1'b0;
	logic mask = 1'b0;
	logic clr = 1'b0;
	logic [3:0] fuse = 4'hA;
	ccc_pstate_t ps = CCC_PS_RUN;
	logic st, bv, te, flag, irq_n, on_en, off_en, chg;
	logic [7:0] bd;
	logic [3:0] code;
	ccc_curr_t cur;
	logic [11:0] mv;
	int failures = 0;
	int compares = 0;
	int cycles = 0;
	ccc_row_t rows [7] = '{
		'{8'h01, CCC_PS_RUN, 1'b1, CCC_I_HIGH},
		'{8'h11, CCC_PS_STBY, 1'b1, CCC_I_LOW},
		'{8'hF0, CCC_PS_RUN, 1'b0, CCC_I_NONE},
		'{8'hE2, CCC_PS_QUICK_POWERUP_OFF_STATE, 1'b1, CCC_I_LOW},
		'{8'h71, CCC_PS_QUICK_POWERUP_OFF_STATE, 1'b0, CCC_I_NONE},
		'{8'h33, CCC_PS_OTHER, 1'b0, CCC_I_NONE},
		'{8'h92, CCC_PS_STBY, 1'b0, CCC_I_NONE}};
	ccc_host u_host (.clk_in(clk_in), .start_out(st), .bv_out(bv), .byte_out(bd), .end_out(te));
	ccc_ctrl dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .fuse_crc_enable_in(crc_en),
		.fuse_backup_charge_voltage_code_in(fuse), .txn_start_in(st), .txn_byte_valid_in(bv),
		.txn_byte_in(bd), .txn_end_in(te), .power_state_in(ps),
		.input_undervoltage_threshold_in(uv), .crc_irq_mask_in(mask), .crc_flag_clear_in(clr),
		.crc_flag_out(flag), .irq_out_n(irq_n), .backup_charge_on_enable_out(on_en),
		.backup_charge_off_enable_out(off_en), .backup_charge_voltage_code_out(code),
		.backup_cell_pin_charge_out(chg), .backup_cell_pin_current_out(cur),
		.backup_cell_pin_target_mv_out(mv));
	initial begin
		forever #2 clk_in = ~clk_in;
	end
	task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic cfg(input logic on, input logic off, input logic [3:0] c);
		check("on_en", on_en, on);
		check("off_en", off_en, off);
		check("code", code, c);
		check("mv", mv, c == 4'h0 ? MV_MIN : c == 4'hF ? MV_MAX : MV_BASE + MV_STEP * (c - 4'h1));
	endtask
	// Bad check byte, then flag, interrupt and configuration checks
	task automatic bad_send(input logic [7:0] flip);
		u_host.send(8'h53, 1'b1, flip);
		@(negedge clk_in);
		check("flag", flag, 1'b1);
		check("irq_n", irq_n, mask);
		cfg(1'b0, 1'b1, 4'h9);
	endtask
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			finish_test();
		end
	end
	initial begin
		repeat (16) @(posedge clk_in);
		check("irq_n", irq_n, 1'b1);
		check("on_en", on_en, 1'b0);
		rst_n_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		@(negedge clk_in);
		cfg(1'b0, 1'b0, 4'hA);
		foreach (rows[i]) begin
			u_host.send(rows[i].cmd, 1'b1, 8'h00);
			ps <= rows[i].ps;
			@(negedge clk_in);
			cfg(rows[i].cmd[0], rows[i].cmd[1], rows[i].cmd[7:4]);
			check("charge", chg, rows[i].chg);
			check("current", cur, rows[i].cur);
		end
		// Every single-bit error in the check byte must be caught
		for (int k = 0; k < 9; k++) begin
			@(posedge clk_in);
			mask <= (k == 8);
			bad_send(8'h01 << (k % 8));
			@(posedge clk_in);
			clr <= 1'b1;
			@(posedge clk_in);
			clr <= 1'b0;
			@(negedge clk_in);
			check("flag", flag, 1'b0);
		end
		@(posedge clk_in);
		crc_en <= 1'b0;
		u_host.send(8'h51, 1'b0, 8'h00);
		@(negedge clk_in);
		cfg(1'b1, 1'b0, 4'h5);
		check("flag", flag, 1'b0);
		@(posedge clk_in);
		crc_en <= 1'b1;
		u_host.send(8'h62, 1'b0, 8'h00);
		@(negedge clk_in);
		check("flag", flag, 1'b1);
		cfg(1'b1, 1'b0, 4'h5);
		// Both crossing directions clear the enables
		for (int k = 0; k < 2; k++) begin
			u_host.send(8'h03, 1'b1, 8'h00);
			@(posedge clk_in);
			uv <= ~uv;
			repeat (2) @(posedge clk_in);
			@(negedge clk_in);
			check("on_en", on_en, 1'b0);
			check("off_en", off_en, 1'b0);
		end
		// Flag still set from the short transaction: unmasked it pulls the interrupt
		@(posedge clk_in);
		mask <= 1'b0;
		@(negedge clk_in);
		check("irq_n", irq_n, 1'b0);
		// Mid-run reset drops the flag and reloads the code from a new fuse value
		@(posedge clk_in);
		rst_n_in <= 1'b0;
		fuse <= 4'h3;
		@(negedge clk_in);
		check("flag", flag, 1'b0);
		check("irq_n", irq_n, 1'b1);
		check("code", code, VCODE_RST);
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		@(negedge clk_in);
		cfg(1'b0, 1'b0, 4'h3);
		finish_test();
	end
endmodule // ccc_ctrl_tb

// *** dv/ccc_host.sv ***
module ccc_host (
	// Clock
	input wire logic clk_in,
	// Transaction strobes
	output logic start_out,
	output logic bv_out,
	output logic [7:0] byte_out,
	output logic end_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		start_out = 1'b0;
		bv_out = 1'b0;
		byte_out = 8'h00;
		end_out = 1'b0;
	end
	// Own CRC rather than the design's, so a shared slip cannot hide
	function automatic logic [7:0] crc8(input logic [7:0] d);
		logic [7:0] c;
		c = 8'hFF ^ d;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ((c << 1) ^ 8'h1D) : (c << 1);
		end
		return c;
	endfunction
	task automatic send(input logic [7:0] cmd, input logic crc_on, input logic [7:0] flip);
		@(posedge clk_in);
		start_out <= 1'b1;
		@(posedge clk_in);
		start_out <= 1'b0;
		bv_out <= 1'b1;
		byte_out <= cmd;
		if (crc_on) begin
			@(posedge clk_in);
			byte_out <= crc8(cmd) ^ flip;
		end
		@(posedge clk_in);
		bv_out <= 1'b0;
		// Released data is inverted so a stale byte cannot pass
		byte_out <= ~byte_out;
		end_out <= 1'b1;
		@(posedge clk_in);
		end_out <= 1'b0;
	endtask
endmodule // ccc_host
